// [core/uie_regs.sv]
`timescale 1ns/1ns
`include "uie_map.svh"
// Contract
// - Enable bit 5 gates the wake-up flag onto the USB interrupt.
// - Enable bit 4 gates the end-of-bus-reset flag onto the interrupt.
// - Enable bit 3 gates the start-of-frame flag onto the interrupt.
// - Enable bit 0 gates the suspend flag onto the interrupt.
// - Enable bits 7-6, 2, 1 read zero; software writes zero there.
// - Address bit 7 switches address filtering on or off.
// - Device address is zero after reset and after every USB bus reset.
// - Start-of-frame flag set on SOF PID; cleared only by software.
// - End-of-reset flag set on bus reset end; software clears it.
// - Wake flag set by non-idle line activity while suspended only.
module uie_regs (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // SFR bus
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   output uie_pkg::uie_byte_t o_sfr_rdata,
   output logic o_sfr_sel,
   // Events from the serial engine
   input wire logic i_suspend_det,
   input wire logic i_sof_det,
   input wire logic i_bus_reset_end,
   input wire logic i_bus_reset,
   input wire logic i_line_active,
   input wire logic i_suspended,
   // Flag clears from the flag register
   input wire logic [3:0] i_flag_clr,
   // Token check
   input wire logic i_tok_valid,
   input wire logic [6:0] i_tok_addr,
   output logic o_tok_accept,
   // Status out
   output logic [3:0] o_flags,
   output uie_pkg::uie_byte_t o_irq_en,
   output uie_pkg::uie_byte_t o_dev_addr_reg,
   output logic o_usb_irq
);
   // ----------------------------------------
   // Register state
   // ----------------------------------------
   uie_pkg::uie_byte_t irq_en_r;
   uie_pkg::uie_byte_t irq_en_nxt;
   logic filter_en_r;
   logic filter_en_nxt;
   uie_pkg::uie_addr_t dev_addr_r;
   uie_pkg::uie_addr_t dev_addr_nxt;
   uie_pkg::uie_byte_t rdata_r;
   uie_pkg::uie_byte_t rdata_nxt;
   logic [3:0] flag_set;
   logic [3:0] flags;
   logic [3:0] src_en;
   logic [3:0] src_hit;
   logic irq_nxt;
   logic hit_irq_en;
   logic hit_addr;
   logic wr_irq_en;
   logic wr_addr;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   assign hit_irq_en = (i_sfr_addr == `UIE_ADDR_IRQ_EN);
   assign hit_addr = (i_sfr_addr == `UIE_ADDR_DEV_ADDR);
   assign wr_irq_en = i_sfr_wr && hit_irq_en;
   assign wr_addr = i_sfr_wr && hit_addr;
   assign o_sfr_sel = hit_irq_en || hit_addr;

   // ----------------------------------------
   // Interrupt enable register
   // ----------------------------------------
   // Reserved bits masked on write, so they can never read back as one
   always_comb begin
      irq_en_nxt = irq_en_r;
      if (wr_irq_en) begin
         irq_en_nxt = i_sfr_wdata & `UIE_IRQ_EN_MASK;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         irq_en_r <= `UIE_IRQ_EN_RST;
      end else begin
         irq_en_r <= irq_en_nxt;
      end
   end

   // ----------------------------------------
   // Address register
   // ----------------------------------------
   always_comb begin
      filter_en_nxt = filter_en_r;
      if (wr_addr) begin
         filter_en_nxt = i_sfr_wdata[`UIE_BIT_FILTER_EN];
      end
   end

   // Filter enable survives bus reset; only core reset or a firmware write with bit 7 low clears it
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         filter_en_r <= 1'b0;
      end else begin
         filter_en_r <= filter_en_nxt;
      end
   end

   // Bus reset outranks a same-cycle firmware write
   always_comb begin
      dev_addr_nxt = dev_addr_r;
      if (i_bus_reset) begin
         dev_addr_nxt = `UIE_DEV_ADDR_RST;
      end else if (wr_addr) begin
         dev_addr_nxt = i_sfr_wdata[6:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         dev_addr_r <= `UIE_DEV_ADDR_RST;
      end else begin
         dev_addr_r <= dev_addr_nxt;
      end
   end

   // ----------------------------------------
   // Event flags
   // ----------------------------------------
   always_comb begin
      flag_set = '0;
      flag_set[3] = i_suspended && i_line_active;
      flag_set[2] = i_bus_reset_end;
      flag_set[1] = i_sof_det;
      flag_set[0] = i_suspend_det;
   end

   uie_flags #(
      .N(4)
   ) u_flags (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_set(flag_set),
      .i_clr(i_flag_clr),
      .o_flag(flags)
   );

   // ----------------------------------------
   // Interrupt
   // ----------------------------------------
   assign src_en[3] = irq_en_r[`UIE_BIT_WAKE];
   assign src_en[2] = irq_en_r[`UIE_BIT_BUS_RESET_END];
   assign src_en[1] = irq_en_r[`UIE_BIT_FRAME_START];
   assign src_en[0] = irq_en_r[`UIE_BIT_SUSPEND];

   // One gate per flag; a cleared enable blocks its source
   genvar g;
   for (g = 0; g < 4; g++) begin : g_src
      assign src_hit[g] = flags[g] & src_en[g];
   end

   assign irq_nxt = |src_hit;

   // Registered so the shared interrupt line never glitches
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_usb_irq <= 1'b0;
      end else begin
         o_usb_irq <= irq_nxt;
      end
   end

   // ----------------------------------------
   // Token filter
   // ----------------------------------------
   // Filter off accepts every token
   assign o_tok_accept = i_tok_valid && (!filter_en_r || i_tok_addr == dev_addr_r);

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Unmapped addresses read zero
   always_comb begin
      rdata_nxt = 8'h00;
      if (i_sfr_rd) begin
         if (hit_irq_en) begin
            rdata_nxt = irq_en_r;
         end else if (hit_addr) begin
            rdata_nxt = {filter_en_r, dev_addr_r};
         end
      end
   end

   // Read data stands for one cycle only
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   assign o_sfr_rdata = rdata_r;
   assign o_flags = flags;
   assign o_irq_en = irq_en_r;
   assign o_dev_addr_reg = {filter_en_r, dev_addr_r};
endmodule : uie_regs

// [core/uie_map.svh]
`ifndef UIE_MAP_SVH
`define UIE_MAP_SVH
// ----------------------------------------
// Register addresses on the SFR bus
// ----------------------------------------
`define UIE_ADDR_IRQ_EN 8'hbe
`define UIE_ADDR_DEV_ADDR 8'hc6
// ----------------------------------------
// Interrupt enable fields
// ----------------------------------------
`define UIE_BIT_WAKE 5
`define UIE_BIT_BUS_RESET_END 4
`define UIE_BIT_FRAME_START 3
`define UIE_BIT_SUSPEND 0
`define UIE_IRQ_EN_MASK 8'h39
`define UIE_IRQ_EN_RST 8'h10
// ----------------------------------------
// Address register fields
// ----------------------------------------
`define UIE_BIT_FILTER_EN 7
`define UIE_DEV_ADDR_RST 7'h00
`define UIE_DEV_ADDR_W 7
`endif

// [core/uie_pkg.sv]
package uie_pkg;
   typedef logic [7:0] uie_byte_t;
   typedef logic [6:0] uie_addr_t;
endpackage : uie_pkg

// [core/uie_flags.sv]
`timescale 1ns/1ns
`include "uie_map.svh"
// ----------------------------------------
// Sticky event flags: set wins over clear
// ----------------------------------------
module uie_flags #(
   parameter int N = 4
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Events and clears
   input wire logic [N-1:0] i_set,
   input wire logic [N-1:0] i_clr,
   // Flags
   output logic [N-1:0] o_flag
);
   logic [N-1:0] flag_r;
   genvar g;
   for (g = 0; g < N; g++) begin : g_flag
      always_ff @(posedge i_clk) begin
         if (!i_rst_n) begin
            flag_r[g] <= 1'b0;
         end else if (i_set[g]) begin
            flag_r[g] <= 1'b1;
         end else if (i_clr[g]) begin
            flag_r[g] <= 1'b0;
         end
      end
   end
   assign o_flag = flag_r;
endmodule : uie_flags

// [sim/uie_regs_asserts.sv]
`timescale 1ns/1ns
module uie_regs_asserts (
   input logic i_clk, i_rst_n, i_sfr_wr, i_sof_det, i_tok_valid, o_tok_accept, o_usb_irq,
   input logic [7:0] i_sfr_addr, i_sfr_wdata, o_irq_en, o_dev_addr_reg,
   input logic [6:0] i_tok_addr,
   input logic [3:0] o_flags
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_sof_set;
      i_sof_det ##1 o_flags[1];
   endsequence
   a_wake_irq: assert property (o_flags[3] && o_irq_en[5] |=> o_usb_irq) else $error("irq");
   a_end_irq: assert property (o_flags[2] && o_irq_en[4] |=> o_usb_irq) else $error("irq");
   a_sof_irq: assert property (o_flags[1] && o_irq_en[3] |=> o_usb_irq) else $error("irq");
   a_susp_irq: assert property (o_flags[0] && o_irq_en[0] |=> o_usb_irq) else $error("irq");
   a_en_write: assert property (i_sfr_wr && i_sfr_addr == 8'hbe |=>
      o_irq_en == ($past(i_sfr_wdata) & 8'h39)) else $error("write");
   a_reset_val: assert property (disable iff (1'b0) !i_rst_n |=>
      o_irq_en == 8'h10) else $error("reset");
   a_sof_flag: assert property (i_sof_det |-> s_sof_set) else $error("flag");
   a_filter_on: assert property (i_tok_valid && o_dev_addr_reg[7] &&
      i_tok_addr != o_dev_addr_reg[6:0] |-> !o_tok_accept) else $error("filter");
endmodule : uie_regs_asserts
bind uie_regs uie_regs_asserts i_chk (.*);

// [sim/uie_sie_model.sv]
`timescale 1ns/1ns
module uie_sie_model (
   input logic i_clk,
   input logic [2:0] i_ev,
   output logic i_suspend_det, i_sof_det, i_bus_reset_end, i_line_active, i_bus_reset,
   output logic i_suspended = 1'b0
);
   assign i_suspend_det = i_ev == 3'h1;
   assign i_sof_det = i_ev == 3'h2;
   assign i_bus_reset_end = i_ev == 3'h3;
   assign i_line_active = i_ev == 3'h4;
   assign i_bus_reset = i_ev == 3'h5;
   // Level: entered on idle, left only on resume
   always @(posedge i_clk) i_suspended <= i_ev == 3'h1 || i_ev != 3'h6 && i_suspended;
endmodule : uie_sie_model

// [sim/usb_irq_enable_and_address_test.sv]
`timescale 1ns/1ns
module usb_irq_enable_and_address_test;
   logic i_clk = 0, i_rst_n = 0, i_sfr_wr = 0, i_sfr_rd = 0, i_tok_valid = 0, s = 0;
   logic [7:0] i_sfr_addr = 0, i_sfr_wdata = 0, o_sfr_rdata, o_irq_en, o_dev_addr_reg;
   logic [7:0] en = 8'h10, ad = 0, rx, ir;
   logic [6:0] i_tok_addr = 0;
   logic [3:0] i_flag_clr = 0, o_flags, f = 0;
   logic [2:0] i_ev = 0;
   logic i_suspend_det, i_sof_det, i_bus_reset_end, i_bus_reset, i_line_active, i_suspended;
   logic o_sfr_sel, o_tok_accept, o_usb_irq, ta;
   int num_errors = 0, checks_done = 0;
   initial forever #25 i_clk = ~i_clk;
   uie_sie_model i_sie (.*);
   uie_regs i_dut (.*);
   task automatic check(logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up();
      $display("%0d checks, %0d mismatches", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   task automatic step(logic [2:0] e, int op, logic [7:0] a, logic [3:0] c);
      @(negedge i_clk);
      i_ev = e;
      i_sfr_wr = op == 1;
      i_sfr_rd = op == 2;
      i_sfr_addr = a;
      // Software keeps reserved enable bits at zero
      i_sfr_wdata = a == 8'hbe ? 8'($urandom) & 8'h39 : 8'($urandom);
      i_flag_clr = c;
      i_tok_valid = $urandom;
      i_tok_addr = $urandom % 2 ? ad[6:0] : 7'($urandom);
      rx = !i_sfr_rd ? 8'h00 : a == 8'hbe ? en : a == 8'hc6 ? ad : 8'h00;
      ir = {7'h00, |(f & {en[5:3], en[0]})};
      f = f & ~c | {e == 4 && s, e == 3, e == 2, e == 1};
      s = e == 1 || e != 6 && s;
      if (i_sfr_wr && a == 8'hbe) en = i_sfr_wdata & 8'h39;
      if (i_sfr_wr && a == 8'hc6) ad = i_sfr_wdata;
      if (e == 5) ad[6:0] = 7'h00;
      @(posedge i_clk);
      #1 check(o_irq_en, en);
      check(o_dev_addr_reg, ad);
      check({4'h0, o_flags}, {4'h0, f});
      check(o_sfr_rdata, rx);
      check({7'h00, o_usb_irq}, ir);
      ta = i_tok_valid && (!ad[7] || i_tok_addr == ad[6:0]);
      check({7'h00, o_tok_accept}, {7'h00, ta});
      check({7'h00, o_sfr_sel}, {7'h00, a == 8'hbe || a == 8'hc6});
   endtask : step
   initial begin
      void'($urandom(32'hb04c));
      repeat (5) @(negedge i_clk);
      i_rst_n = 1;
      step(0, 2, 8'hbe, 0);
      step(0, 2, 8'hc6, 0);
      $display("reset test done");
      repeat (400) step($urandom % 7, $urandom % 3,
         $urandom % 3 == 0 ? 8'hbe : $urandom % 2 ? 8'hc6 : 8'($urandom),
         $urandom % 4 ? 4'h0 : 4'($urandom));
      $display("random test done");
      wrap_up();
   end
   initial begin
      #50000;
      num_errors++;
      wrap_up();
   end
endmodule : usb_irq_enable_and_address_test
